// >>> tsec_capture.sv
// time sync event capture unit: counter, port capture, event queue, registers
`timescale 1ns/1ps
module tsec_capture #(
   parameter int NUM_PORTS = tsec_pkg::NUM_PORTS_BASE,
   parameter int FIFO_DEPTH = tsec_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [tsec_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [NUM_PORTS-1:0] rx_sof,
   input wire tsec_pkg::tsec_pkt_t [NUM_PORTS-1:0] rx_pkt,
   input wire logic [NUM_PORTS-1:0] tx_sof,
   input wire tsec_pkg::tsec_pkt_t [NUM_PORTS-1:0] tx_pkt,
   output logic event_pending
);
   localparam int NSRC = 3 + 2 * NUM_PORTS;
   localparam int CW = $clog2(FIFO_DEPTH+1);
   localparam int SRC_PUSH = 0;
   localparam int SRC_ROLL = 1;
   localparam int SRC_HALF = 2;
   localparam int SRC_PORT0 = 3;

   logic timesync_enable_ff;
   logic pending_irq_enable_ff;
   logic [tsec_pkg::TS_W-1:0] ts_ff;
   logic push_pend_ff;
   logic [tsec_pkg::TS_W-1:0] push_ts_ff;
   logic roll_pend_ff;
   logic half_pend_ff;
   logic raw_event_status_ff;
   logic event_pending_ff;
   logic [31:0] rdata_ff;
   logic nxt_raw;
   logic wr_ctrl;
   logic wr_inten;
   logic wr_push;
   logic wr_pop;
   logic [NSRC-1:0] src_req;
   logic [NSRC-1:0] src_grant;
   tsec_pkg::tsec_evt_t src_evt [NSRC];
   tsec_pkg::tsec_evt_t win_evt;
   logic any_req;
   tsec_pkg::tsec_evt_t head;
   logic [CW-1:0] fifo_count;

   // high word layout of an event record
   function automatic logic [31:0] hi_word(input tsec_pkg::tsec_evt_t e);
      logic [31:0] w;
      w = '0;
      w[tsec_pkg::HI_SEQ_LSB +: 16] = e.seq_id;
      w[tsec_pkg::HI_MSG_LSB +: 4] = e.msg_type;
      w[tsec_pkg::HI_TYPE_LSB +: 4] = e.etype;
      w[tsec_pkg::HI_PORT_LSB +: tsec_pkg::PORT_W] = e.port;
      return w;
   endfunction

   // builds a locally sourced event with no packet fields
   function automatic tsec_pkg::tsec_evt_t local_evt(input tsec_pkg::tsec_evt_type_t t,
                                                     input logic [31:0] ts);
      tsec_pkg::tsec_evt_t e;
      e = '0;
      e.etype = t;
      e.ts = ts;
      return e;
   endfunction

   // register write decode
   always_comb begin
      wr_ctrl = 1'b0;
      wr_inten = 1'b0;
      wr_push = 1'b0;
      wr_pop = 1'b0;
      if (reg_wr && reg_addr == tsec_pkg::CTRL_OFS) begin
         wr_ctrl = 1'b1;
      end else if (reg_wr && reg_addr == tsec_pkg::INTEN_OFS) begin
         wr_inten = 1'b1;
      end else if (reg_wr && reg_addr == tsec_pkg::PUSH_OFS) begin
         wr_push = 1'b1;
      end else if (reg_wr && reg_addr == tsec_pkg::POP_OFS) begin
         wr_pop = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         timesync_enable_ff <= tsec_pkg::CTRL_EN_RST;
      end else if (wr_ctrl) begin
         timesync_enable_ff <= reg_wdata[tsec_pkg::CTRL_EN_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pending_irq_enable_ff <= tsec_pkg::PEND_EN_RST;
      end else if (wr_inten) begin
         pending_irq_enable_ff <= reg_wdata[tsec_pkg::INTEN_PEND_BIT];
      end
   end

   // stamp counter, held at zero while disabled; upper bits are kept by software
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ts_ff <= tsec_pkg::TS_RST;
      end else if (!timesync_enable_ff) begin
         ts_ff <= tsec_pkg::TS_RST;
      end else begin
         ts_ff <= ts_ff + 32'h0000_0001;
      end
   end

   // local event sources hold a request until it is granted, even by a full queue; set wins over grant
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         push_pend_ff <= 1'b0;
         push_ts_ff <= '0;
      end else if (wr_push) begin
         push_pend_ff <= 1'b1;
         push_ts_ff <= ts_ff;
      end else if (src_grant[SRC_PUSH]) begin
         push_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         roll_pend_ff <= 1'b0;
      end else if (timesync_enable_ff && ts_ff == tsec_pkg::TS_FULL_LAST) begin
         roll_pend_ff <= 1'b1;
      end else if (src_grant[SRC_ROLL]) begin
         roll_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         half_pend_ff <= 1'b0;
      end else if (timesync_enable_ff && ts_ff == tsec_pkg::TS_HALF_LAST) begin
         half_pend_ff <= 1'b1;
      end else if (src_grant[SRC_HALF]) begin
         half_pend_ff <= 1'b0;
      end
   end

   // rollover stamps carry the live count but have no meaning to software
   assign src_req[SRC_PUSH] = push_pend_ff;
   assign src_req[SRC_ROLL] = roll_pend_ff;
   assign src_req[SRC_HALF] = half_pend_ff;
   assign src_evt[SRC_PUSH] = local_evt(tsec_pkg::EVT_PUSH, push_ts_ff);
   assign src_evt[SRC_ROLL] = local_evt(tsec_pkg::EVT_ROLL, ts_ff);
   assign src_evt[SRC_HALF] = local_evt(tsec_pkg::EVT_HALF, ts_ff);

   // one receive and one transmit capture per port, ports numbered from one
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      tsec_stamp_cap #(
         .PORT_NUM(tsec_pkg::PORT_W'(p + 1)),
         .EVT_TYPE(tsec_pkg::EVT_RX)
      ) u_rx (
         .ref_clk(ref_clk),
         .rst_b(rst_b),
         .sof(rx_sof[p]),
         .pkt(rx_pkt[p]),
         .cur_ts(ts_ff),
         .grant(src_grant[SRC_PORT0 + 2 * p]),
         .req(src_req[SRC_PORT0 + 2 * p]),
         .evt(src_evt[SRC_PORT0 + 2 * p])
      );
      tsec_stamp_cap #(
         .PORT_NUM(tsec_pkg::PORT_W'(p + 1)),
         .EVT_TYPE(tsec_pkg::EVT_TX)
      ) u_tx (
         .ref_clk(ref_clk),
         .rst_b(rst_b),
         .sof(tx_sof[p]),
         .pkt(tx_pkt[p]),
         .cur_ts(ts_ff),
         .grant(src_grant[SRC_PORT0 + 2 * p + 1]),
         .req(src_req[SRC_PORT0 + 2 * p + 1]),
         .evt(src_evt[SRC_PORT0 + 2 * p + 1])
      );
   end

   // fixed priority, lowest index first; one event enters the queue per clock
   always_comb begin
      src_grant = '0;
      win_evt = '0;
      any_req = 1'b0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (src_req[i]) begin
            src_grant = '0;
            src_grant[i] = 1'b1;
            win_evt = src_evt[i];
            any_req = 1'b1;
         end
      end
   end

   // a full queue still grants, so the event is lost without a flag
   tsec_evt_fifo #(
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .in_valid(any_req),
      .in_data(win_evt),
      .pop(wr_pop),
      .head(head),
      .count(fifo_count)
   );

   assign nxt_raw = (fifo_count != '0);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         raw_event_status_ff <= 1'b0;
      end else begin
         raw_event_status_ff <= nxt_raw;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         event_pending_ff <= 1'b0;
      end else begin
         event_pending_ff <= nxt_raw && pending_irq_enable_ff;
      end
   end

   // read data stands only in the cycle after the read strobe
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= '0;
      end else if (!reg_rd) begin
         rdata_ff <= '0;
      end else if (reg_addr == tsec_pkg::CTRL_OFS) begin
         rdata_ff <= 32'(timesync_enable_ff);
      end else if (reg_addr == tsec_pkg::INTEN_OFS) begin
         rdata_ff <= 32'(pending_irq_enable_ff);
      end else if (reg_addr == tsec_pkg::RAW_OFS) begin
         rdata_ff <= 32'(nxt_raw);
      end else if (reg_addr == tsec_pkg::EVT_LOW_OFS) begin
         rdata_ff <= nxt_raw ? head.ts : '0;
      end else if (reg_addr == tsec_pkg::EVT_MID_OFS) begin
         rdata_ff <= nxt_raw ? 32'(head.domain) << tsec_pkg::MID_DOM_LSB : '0;
      end else if (reg_addr == tsec_pkg::EVT_HIGH_OFS) begin
         rdata_ff <= nxt_raw ? hi_word(head) : '0;
      end else if (reg_addr == tsec_pkg::COUNT_OFS) begin
         rdata_ff <= 32'(fifo_count);
      end else begin
         rdata_ff <= '0;
      end
   end

   assign reg_rdata = rdata_ff;
   assign event_pending = event_pending_ff;

   a_cnt_held_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !timesync_enable_ff |=> ts_ff == tsec_pkg::TS_RST)
      else $error("counter moved while disabled");
   a_cnt_counts: assert property (@(posedge ref_clk) disable iff (!rst_b)
      timesync_enable_ff |=> ts_ff == $past(ts_ff) + 32'h0000_0001)
      else $error("counter missed an increment");
   a_roll_event: assert property (@(posedge ref_clk) disable iff (!rst_b)
      timesync_enable_ff && ts_ff == tsec_pkg::TS_FULL_LAST
      |=> roll_pend_ff && ts_ff == tsec_pkg::TS_RST)
      else $error("wrap did not raise a rollover event");
   a_half_event: assert property (@(posedge ref_clk) disable iff (!rst_b)
      timesync_enable_ff && ts_ff == tsec_pkg::TS_HALF_LAST
      |=> half_pend_ff && ts_ff[31])
      else $error("midpoint did not raise a half rollover event");
   a_push_stamp: assert property (@(posedge ref_clk) disable iff (!rst_b)
      wr_push |=> push_pend_ff && push_ts_ff == $past(ts_ff))
      else $error("push event not stamped at the write");
   a_push_queued: assert property (@(posedge ref_clk) disable iff (!rst_b)
      push_pend_ff && !wr_push |-> ##[0:2] src_grant[SRC_PUSH])
      else $error("push event not queued in time");
   a_raw_status: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ##1 raw_event_status_ff == $past(nxt_raw))
      else $error("raw status disagrees with queue fill");
   a_pend_gated: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !pending_irq_enable_ff |=> !event_pending_ff)
      else $error("pending raised while disabled");
   a_pend_follows: assert property (@(posedge ref_clk) disable iff (!rst_b)
      nxt_raw && pending_irq_enable_ff |=> event_pending_ff)
      else $error("pending missing with events queued");

   // bus and queue bookkeeping; the full-drop check is the only trace of a lost event
   a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !reg_rd |=> reg_rdata == '0)
      else $error("read data stood outside its cycle");
   a_low_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
      reg_rd && reg_addr == tsec_pkg::EVT_LOW_OFS && nxt_raw |=> reg_rdata == $past(head.ts))
      else $error("low word did not show the head stamp");
   a_empty_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
      reg_rd && !nxt_raw && reg_addr >= tsec_pkg::EVT_LOW_OFS
      && reg_addr <= tsec_pkg::EVT_HIGH_OFS |=> reg_rdata == '0)
      else $error("empty queue read returned data");
   a_queue_entry: assert property (@(posedge ref_clk) disable iff (!rst_b)
      any_req && !wr_pop && fifo_count != CW'(FIFO_DEPTH)
      |=> fifo_count == CW'($past(fifo_count) + 1'b1))
      else $error("granted event did not enter the queue");
   a_full_drop: assert property (@(posedge ref_clk) disable iff (!rst_b)
      any_req && !wr_pop && fifo_count == CW'(FIFO_DEPTH) |=> fifo_count == CW'(FIFO_DEPTH))
      else $error("full queue changed on a dropped event");
   a_pop_advance: assert property (@(posedge ref_clk) disable iff (!rst_b)
      wr_pop && !any_req && fifo_count != '0 |=> fifo_count == CW'($past(fifo_count) - 1'b1))
      else $error("acknowledge did not drop the head event");
   a_pend_empty: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !nxt_raw |=> !event_pending_ff)
      else $error("pending raised with an empty queue");
   a_ctrl_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
      wr_ctrl |=> timesync_enable_ff == $past(reg_wdata[tsec_pkg::CTRL_EN_BIT]))
      else $error("module enable write not taken");
   a_inten_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
      wr_inten |=> pending_irq_enable_ff == $past(reg_wdata[tsec_pkg::INTEN_PEND_BIT]))
      else $error("pending enable write not taken");
   a_eth_port: assert property (@(posedge ref_clk) disable iff (!rst_b)
      nxt_raw && (head.etype == tsec_pkg::EVT_RX || head.etype == tsec_pkg::EVT_TX)
      |-> head.port != '0)
      else $error("ethernet event without a port number");
endmodule

// >>> tsec_pkg.sv
// shared constants, event types and carriers of the time sync event capture unit
package tsec_pkg;
   localparam int TS_W = 32;
   localparam int ADDR_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int NUM_PORTS_BASE = 2;
   localparam int PORT_W = 5;

   // register offsets (byte addresses, one aligned word each)
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] INTEN_OFS = 8'h04;
   localparam logic [7:0] PUSH_OFS = 8'h08;
   localparam logic [7:0] RAW_OFS = 8'h0C;
   localparam logic [7:0] POP_OFS = 8'h10;
   localparam logic [7:0] EVT_LOW_OFS = 8'h14;
   localparam logic [7:0] EVT_MID_OFS = 8'h18;
   localparam logic [7:0] EVT_HIGH_OFS = 8'h1C;
   localparam logic [7:0] COUNT_OFS = 8'h20;

   // field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int INTEN_PEND_BIT = 0;
   localparam int RAW_EVT_BIT = 0;
   localparam int HI_SEQ_LSB = 0;
   localparam int HI_MSG_LSB = 16;
   localparam int HI_TYPE_LSB = 20;
   localparam int HI_PORT_LSB = 24;
   localparam int MID_DOM_LSB = 0;

   // reset values and counter landmarks
   localparam logic CTRL_EN_RST = 1'b0;
   localparam logic PEND_EN_RST = 1'b0;
   localparam logic [31:0] TS_RST = 32'h0000_0000;
   localparam logic [31:0] TS_HALF_LAST = 32'h7FFF_FFFF;
   localparam logic [31:0] TS_FULL_LAST = 32'hFFFF_FFFF;

   typedef enum logic [3:0] {
      EVT_PUSH = 4'h0,
      EVT_ROLL = 4'h1,
      EVT_HALF = 4'h2,
      EVT_HWPUSH = 4'h3,
      EVT_RX = 4'h4,
      EVT_TX = 4'h5,
      EVT_CMP = 4'h6
   } tsec_evt_type_t;

   // one packet report from a switch port datapath
   typedef struct packed {
      logic done;
      logic is_sync;
      logic [3:0] msg_type;
      logic [15:0] seq_id;
      logic [7:0] domain;
   } tsec_pkt_t;

   // one queued event record
   typedef struct packed {
      logic [7:0] domain;
      logic [PORT_W-1:0] port;
      tsec_evt_type_t etype;
      logic [3:0] msg_type;
      logic [15:0] seq_id;
      logic [TS_W-1:0] ts;
   } tsec_evt_t;
endpackage

// >>> tsec_evt_fifo.sv
// event queue held in flip-flops; head stays visible until popped
`timescale 1ns/1ps
module tsec_evt_fifo #(
   parameter int DEPTH = tsec_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic in_valid,
   input wire tsec_pkg::tsec_evt_t in_data,
   input wire logic pop,
   output tsec_pkg::tsec_evt_t head,
   output logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   tsec_pkg::tsec_evt_t mem_ff [DEPTH];
   logic [PW-1:0] wr_ptr_ff;
   logic [PW-1:0] rd_ptr_ff;
   logic [CW-1:0] count_ff;
   logic do_wr;
   logic do_rd;

   // a full queue drops silently: there is no overrun flag
   assign do_wr = in_valid && (count_ff != CW'(DEPTH));
   assign do_rd = pop && (count_ff != '0);

   always_ff @(posedge ref_clk) begin
      if (do_wr) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (do_wr) wr_ptr_ff <= PW'(wr_ptr_ff + 1'b1);
         if (do_rd) rd_ptr_ff <= PW'(rd_ptr_ff + 1'b1);
         count_ff <= CW'(count_ff + (do_wr ? 1'b1 : 1'b0) - (do_rd ? 1'b1 : 1'b0));
      end
   end

   assign head = mem_ff[rd_ptr_ff];
   assign count = count_ff;

   a_fifo_capacity: assert property (@(posedge ref_clk) disable iff (!rst_b)
      count_ff <= CW'(DEPTH)) else $error("event queue holds more than its depth");
   a_head_held: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (count_ff != '0) && !pop |=> $stable(rd_ptr_ff) && (count_ff != '0))
      else $error("head event moved without an acknowledge");
endmodule

// >>> tsec_stamp_cap.sv
// per-direction port capture: stamp at frame start, report after validation
`timescale 1ns/1ps
module tsec_stamp_cap #(
   parameter logic [tsec_pkg::PORT_W-1:0] PORT_NUM = 5'h01,
   parameter tsec_pkg::tsec_evt_type_t EVT_TYPE = tsec_pkg::EVT_RX
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic sof,
   input wire tsec_pkg::tsec_pkt_t pkt,
   input wire logic [tsec_pkg::TS_W-1:0] cur_ts,
   input wire logic grant,
   output logic req,
   output tsec_pkg::tsec_evt_t evt
);
   logic [tsec_pkg::TS_W-1:0] stamp_ff;
   logic req_ff;
   tsec_pkg::tsec_evt_t evt_ff;
   logic report;

   assign report = pkt.done && pkt.is_sync;

   // every frame is stamped, sync or not, so no time is lost parsing
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stamp_ff <= '0;
      end else if (sof) begin
         stamp_ff <= cur_ts;
      end
   end

   // a new report wins over a grant in the same cycle
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_ff <= 1'b0;
      end else if (report) begin
         req_ff <= 1'b1;
      end else if (grant) begin
         req_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         evt_ff <= '0;
      end else if (report) begin
         evt_ff.ts <= stamp_ff;
         evt_ff.port <= PORT_NUM;
         evt_ff.etype <= EVT_TYPE;
         evt_ff.msg_type <= pkt.msg_type;
         evt_ff.seq_id <= pkt.seq_id;
         evt_ff.domain <= pkt.domain;
      end
   end

   assign req = req_ff;
   assign evt = evt_ff;

   a_sof_stamp: assert property (@(posedge ref_clk) disable iff (!rst_b)
      sof |=> stamp_ff == $past(cur_ts)) else $error("frame start not stamped");
   a_report_req: assert property (@(posedge ref_clk) disable iff (!rst_b)
      report |=> req_ff && evt_ff.ts == $past(stamp_ff) && evt_ff.etype == EVT_TYPE)
      else $error("validated packet not reported");
endmodule

// >>> tsec_port_model.sv
// switch port datapath model feeding start delimiters and packet reports
`timescale 1ns/1ps
module tsec_port_model #(
   parameter int NUM_PORTS = 2
) (
   input wire logic ref_clk,
   output logic [NUM_PORTS-1:0] rx_sof,
   output tsec_pkg::tsec_pkt_t [NUM_PORTS-1:0] rx_pkt,
   output logic [NUM_PORTS-1:0] tx_sof,
   output tsec_pkg::tsec_pkt_t [NUM_PORTS-1:0] tx_pkt
);
   initial begin
      rx_sof = '0;
      tx_sof = '0;
      rx_pkt = '0;
      tx_pkt = '0;
   end

   // one packet: start delimiter, parse time, then the report pulse
   task automatic send(input bit dir, input int p, input bit sync, input logic [3:0] msg,
                       input logic [15:0] seq, input logic [7:0] dom, input int gap);
      tsec_pkg::tsec_pkt_t k;
      tsec_pkg::tsec_pkt_t idle;
      k = '{done: 1'b1, is_sync: sync, msg_type: msg, seq_id: seq, domain: dom};
      idle = ~k;
      idle.done = 1'b0;
      @(posedge ref_clk);
      if (dir) tx_sof[p] <= 1'b1;
      else rx_sof[p] <= 1'b1;
      @(posedge ref_clk);
      tx_sof[p] <= 1'b0;
      rx_sof[p] <= 1'b0;
      // report comes only after parsing, so the stamp is older than the report
      repeat (gap) @(posedge ref_clk);
      if (dir) tx_pkt[p] <= k;
      else rx_pkt[p] <= k;
      @(posedge ref_clk);
      // fields carry garbage outside the report cycle, never the old value
      if (dir) tx_pkt[p] <= idle;
      else rx_pkt[p] <= idle;
   endtask
endmodule

// >>> tb_tsec_capture.sv
// self-checking bench of the time sync event capture unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      mismatches++; \
      $display("unexpected %s expected %h seen %h", nm, e, g); \
   end \
end
module tb_tsec_capture;
   typedef struct {string nm; logic [31:0] exp; int mode;} tsec_note_t;
   localparam int NP = 4;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic event_pending;
   logic [NP-1:0] rx_sof;
   logic [NP-1:0] tx_sof;
   tsec_pkg::tsec_pkt_t [NP-1:0] rx_pkt;
   tsec_pkg::tsec_pkt_t [NP-1:0] tx_pkt;
   tsec_note_t notes[$];
   tsec_note_t n;
   logic rd_seen = 1'b0;
   logic [31:0] base_ts = 32'h0;
   logic [31:0] lfsr = 32'h23C1D1D1;
   logic [31:0] hi;
   int mismatches = 0;
   int cmp_count = 0;
   int i;

   tsec_capture #(.NUM_PORTS(NP), .FIFO_DEPTH(tsec_pkg::FIFO_DEPTH)) dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_sof(rx_sof),
      .rx_pkt(rx_pkt), .tx_sof(tx_sof), .tx_pkt(tx_pkt), .event_pending(event_pending));
   tsec_port_model #(.NUM_PORTS(NP)) pm (
      .ref_clk(ref_clk), .rx_sof(rx_sof), .rx_pkt(rx_pkt), .tx_sof(tx_sof), .tx_pkt(tx_pkt));

   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // mode 0 absolute, 1 relative to the last base stamp, 2 takes a new base
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, input int m);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      notes.push_back('{nm, e, m});
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask

   task automatic pend(input logic e);
      @(negedge ref_clk);
      `CHK("event_pending", e, event_pending)
   endtask

   // read data stand only in the cycle after the strobe
   always @(posedge ref_clk) rd_seen <= reg_rd;
   always @(negedge ref_clk) begin
      if (rd_seen) begin
         n = notes.pop_front();
         if (n.mode == 2) base_ts = reg_rdata;
         // wrap-safe stamp difference: no upper-count correction is needed here
         else if (n.mode == 1) `CHK(n.nm, n.exp, reg_rdata - base_ts)
         else `CHK(n.nm, n.exp, reg_rdata)
      end
   end

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge ref_clk);
      mismatches++;
      give_verdict();
   end

   initial begin
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      rd("ctrl", tsec_pkg::CTRL_OFS, 32'h0, 0);
      rd("inten", tsec_pkg::INTEN_OFS, 32'h0, 0);
      rd("raw", tsec_pkg::RAW_OFS, 32'h0, 0);
      rd("low", tsec_pkg::EVT_LOW_OFS, 32'h0, 0);
      rd("unmapped", 8'h3C, 32'h0, 0);
      wr(8'h3C, 32'hFFFF_FFFF);
      rd("ctrl", tsec_pkg::CTRL_OFS, 32'h0, 0);
      // counter disabled: every push stamps zero; two extra pushes overflow the queue
      for (i = 0; i < tsec_pkg::FIFO_DEPTH + 2; i++) begin
         lfsr = lfsr_next(lfsr);
         wr(tsec_pkg::PUSH_OFS, lfsr);
      end
      repeat (4) @(posedge ref_clk);
      rd("count", tsec_pkg::COUNT_OFS, 32'(tsec_pkg::FIFO_DEPTH), 0);
      rd("raw", tsec_pkg::RAW_OFS, 32'h1, 0);
      rd("low", tsec_pkg::EVT_LOW_OFS, 32'h0, 0);
      hi = 32'(tsec_pkg::EVT_PUSH) << tsec_pkg::HI_TYPE_LSB;
      rd("high", tsec_pkg::EVT_HIGH_OFS, hi, 0);
      pend(1'b0);
      wr(tsec_pkg::INTEN_OFS, 32'h1);
      repeat (2) @(posedge ref_clk);
      pend(1'b1);
      for (i = 0; i < tsec_pkg::FIFO_DEPTH; i++) wr(tsec_pkg::POP_OFS, 32'h0);
      repeat (3) @(posedge ref_clk);
      rd("count", tsec_pkg::COUNT_OFS, 32'h0, 0);
      rd("raw", tsec_pkg::RAW_OFS, 32'h0, 0);
      pend(1'b0);
      wr(tsec_pkg::CTRL_OFS, 32'h1);
      rd("ctrl", tsec_pkg::CTRL_OFS, 32'h1, 0);
      wr(tsec_pkg::PUSH_OFS, 32'h0);
      repeat (7) @(posedge ref_clk);
      wr(tsec_pkg::PUSH_OFS, 32'h0);
      repeat (4) @(posedge ref_clk);
      rd("low", tsec_pkg::EVT_LOW_OFS, 32'h0, 2);
      rd("low again", tsec_pkg::EVT_LOW_OFS, 32'h0, 1);
      wr(tsec_pkg::POP_OFS, 32'h0);
      // seven idle edges plus the second write task's setup and capture edges
      rd("push delta", tsec_pkg::EVT_LOW_OFS, 32'h9, 1);
      wr(tsec_pkg::POP_OFS, 32'h0);
      for (i = 0; i < 2 * NP; i++) begin
         lfsr = lfsr_next(lfsr);
         hi = 32'(lfsr[15:0]) << tsec_pkg::HI_SEQ_LSB;
         hi = hi | (32'(lfsr[19:16]) << tsec_pkg::HI_MSG_LSB);
         hi = hi | (32'((i % 2) ? tsec_pkg::EVT_TX : tsec_pkg::EVT_RX) << tsec_pkg::HI_TYPE_LSB);
         hi = hi | (32'(i / 2 + 1) << tsec_pkg::HI_PORT_LSB);
         wr(tsec_pkg::PUSH_OFS, 32'h0);
         pm.send(i % 2, i / 2, 1'b1, lfsr[19:16], lfsr[15:0], lfsr[27:20], 3);
         repeat (6) @(posedge ref_clk);
         rd("low", tsec_pkg::EVT_LOW_OFS, 32'h0, 2);
         wr(tsec_pkg::POP_OFS, 32'h0);
         // start delimiter is taken two edges after the push write
         rd("eth stamp", tsec_pkg::EVT_LOW_OFS, 32'h2, 1);
         rd("high", tsec_pkg::EVT_HIGH_OFS, hi, 0);
         rd("mid", tsec_pkg::EVT_MID_OFS, 32'(lfsr[27:20]), 0);
         wr(tsec_pkg::POP_OFS, 32'h0);
         pm.send(i % 2, i / 2, 1'b0, lfsr[3:0], lfsr[31:16], lfsr[7:0], 1);
         repeat (6) @(posedge ref_clk);
         rd("count", tsec_pkg::COUNT_OFS, 32'h0, 0);
      end
      repeat (2) @(posedge ref_clk);
      give_verdict();
   end
endmodule
